// >>> rtl/mux_write_seq.sv
// multiplexed 16-bit host-port write sequencer, bus master side
//
// Function
// - address driven with chip select active, valid 11 to 45 bus clocks
// - data strobe goes active no sooner than 34 clocks after chip select
// - data strobe pulse lasts 4 to 5 clocks on a write
// - write data valid 4 to 5 clocks before strobe rises
// - write data held 4 to 36 clocks after strobe rises
// - recovery gap of 2 to 17 clocks between accesses
// - while ready/wait is asserted, address or strobe phase does not advance
// - after ready/wait drops, address phase holds one more clock at least
// - every count is in expansion bus clock periods
`timescale 1ns/1ps
`default_nettype none

module mux_write_seq (
    input wire logic i_mclk,                        // expansion bus clock, 250 MHz
    input wire logic i_rst_b,                       // synchronous reset, active low
    input wire logic i_ce,                          // clock enable, freezes all state when low
    input wire logic i_wr_req,                      // start a write access (taken in idle)
    input wire logic [15:0] i_wr_addr,              // address for the access
    input wire logic [15:0] i_wr_data,              // data for the access
    input wire logic [5:0] i_address_phase_param,   // address phase length
    input wire logic [5:0] i_setup_phase_param,     // setup phase parameter
    input wire logic [5:0] i_strobe_phase_param,    // strobe phase length
    input wire logic [5:0] i_recovery_phase_param,  // recovery phase length
    input wire logic i_host_ready_wait,             // wait pin from the dsp, active high
    output logic o_chip_select_low,                 // chip select, active low
    output logic o_host_data_strobe_low,            // host data strobe, active low
    output logic [15:0] o_ad_out,                   // multiplexed address/data out
    output logic o_ad_oe,                           // drive enable for the ad bus
    output logic o_busy,                            // access in progress
    output logic o_done                             // one-cycle pulse at end of recovery
);
    // ==========================================================
    // pin synchroniser
    logic rdy_meta_q;
    logic rdy_sync_q;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            rdy_meta_q <= 1'b0;
            rdy_sync_q <= 1'b0;
        end else if (i_ce) begin
            rdy_meta_q <= i_host_ready_wait;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    // ==========================================================
    // phase lengths, clamped so any programming meets the bus limits
    logic [5:0] addr_len;
    logic [5:0] setup_len;
    logic [5:0] strobe_len;
    logic [5:0] recov_len;
    always_comb begin
        addr_len = i_address_phase_param;
        if (addr_len < mux_write_pkg::ADDR_MIN) addr_len = mux_write_pkg::ADDR_MIN;
        if (addr_len > mux_write_pkg::ADDR_MAX) addr_len = mux_write_pkg::ADDR_MAX;
        // setup parameter n gives n+1 clocks; below the minimum it is raised
        setup_len = i_setup_phase_param + 6'h01;
        if (i_setup_phase_param < mux_write_pkg::SETUP_PARAM_MIN) begin
            setup_len = mux_write_pkg::SETUP_PARAM_MIN + 6'h01;
        end
        strobe_len = i_strobe_phase_param;
        if (strobe_len < mux_write_pkg::STROBE_MIN) strobe_len = mux_write_pkg::STROBE_MIN;
        if (strobe_len > mux_write_pkg::STROBE_MAX) strobe_len = mux_write_pkg::STROBE_MAX;
        recov_len = i_recovery_phase_param;
        if (recov_len < mux_write_pkg::RECOV_MIN) recov_len = mux_write_pkg::RECOV_MIN;
        if (recov_len > mux_write_pkg::RECOV_MAX) recov_len = mux_write_pkg::RECOV_MAX;
    end

    // ==========================================================
    // sequencer
    mux_write_pkg::phase_e st_q, st_d;
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] cs_age_q, cs_age_d;
    logic extra_q, extra_d;
    logic [15:0] addr_q, addr_d;
    logic [15:0] data_q, data_d;
    logic cs_n_d, hds_n_d, oe_d, busy_d, done_d;
    logic [15:0] ad_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 6'h01;
        cs_age_d = cs_age_q;
        extra_d = extra_q;
        addr_d = addr_q;
        data_d = data_q;
        done_d = 1'b0;
        // chip select age saturates once the strobe may fire
        if (cs_age_q < mux_write_pkg::CS2STROBE_MIN) cs_age_d = cs_age_q + 6'h01;
        unique case (st_q)
            mux_write_pkg::ST_IDLE: begin
                cnt_d = mux_write_pkg::CNT_RST;
                cs_age_d = mux_write_pkg::CNT_RST;
                extra_d = 1'b0;
                if (i_wr_req) begin
                    st_d = mux_write_pkg::ST_ADDR;
                    addr_d = i_wr_addr;
                    data_d = i_wr_data;
                end
            end
            mux_write_pkg::ST_ADDR: begin
                if (rdy_sync_q) begin
                    cnt_d = cnt_q;
                    extra_d = 1'b1;
                end else if (extra_q) begin
                    // wait just ended: spend one more clock in address phase
                    cnt_d = cnt_q;
                    extra_d = 1'b0;
                end else if (cnt_q >= addr_len - 6'h01) begin
                    st_d = mux_write_pkg::ST_SETUP;
                    cnt_d = mux_write_pkg::CNT_RST;
                end
            end
            mux_write_pkg::ST_SETUP: begin
                // both the setup length and the chip-select delay must be met
                if (cnt_q >= setup_len - 6'h01
                        && cs_age_q >= mux_write_pkg::CS2STROBE_MIN - 6'h01) begin
                    st_d = mux_write_pkg::ST_STROBE;
                    cnt_d = mux_write_pkg::CNT_RST;
                end
            end
            mux_write_pkg::ST_STROBE: begin
                if (rdy_sync_q) begin
                    cnt_d = cnt_q;
                end else if (cnt_q >= strobe_len - 6'h01) begin
                    st_d = mux_write_pkg::ST_HOLD;
                    cnt_d = mux_write_pkg::CNT_RST;
                end
            end
            mux_write_pkg::ST_HOLD: begin
                if (cnt_q >= mux_write_pkg::HOLD_LEN - 6'h01) begin
                    st_d = mux_write_pkg::ST_RECOV;
                    cnt_d = mux_write_pkg::CNT_RST;
                end
            end
            mux_write_pkg::ST_RECOV: begin
                if (cnt_q >= recov_len - 6'h01) begin
                    st_d = mux_write_pkg::ST_IDLE;
                    cnt_d = mux_write_pkg::CNT_RST;
                    done_d = 1'b1;
                end
            end
            default: begin
                st_d = mux_write_pkg::ST_IDLE;
                cnt_d = mux_write_pkg::CNT_RST;
            end
        endcase
        // pin levels follow the next phase so every output is a flop
        cs_n_d = (st_d == mux_write_pkg::ST_IDLE) || (st_d == mux_write_pkg::ST_RECOV);
        hds_n_d = (st_d != mux_write_pkg::ST_STROBE);
        busy_d = (st_d != mux_write_pkg::ST_IDLE);
        oe_d = 1'b0;
        ad_d = mux_write_pkg::BUS_RST;
        if (st_d == mux_write_pkg::ST_ADDR || st_d == mux_write_pkg::ST_SETUP) begin
            oe_d = 1'b1;
            ad_d = addr_d;
        end else if (st_d == mux_write_pkg::ST_STROBE || st_d == mux_write_pkg::ST_HOLD) begin
            oe_d = 1'b1;
            ad_d = data_d;
        end
    end

    // all counts advance only on enabled bus clock edges
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st_q <= mux_write_pkg::ST_IDLE;
            cnt_q <= mux_write_pkg::CNT_RST;
            cs_age_q <= mux_write_pkg::CNT_RST;
            extra_q <= 1'b0;
            addr_q <= mux_write_pkg::BUS_RST;
            data_q <= mux_write_pkg::BUS_RST;
            o_chip_select_low <= 1'b1;
            o_host_data_strobe_low <= 1'b1;
            o_ad_out <= mux_write_pkg::BUS_RST;
            o_ad_oe <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cs_age_q <= cs_age_d;
            extra_q <= extra_d;
            addr_q <= addr_d;
            data_q <= data_d;
            o_chip_select_low <= cs_n_d;
            o_host_data_strobe_low <= hds_n_d;
            o_ad_out <= ad_d;
            o_ad_oe <= oe_d;
            o_busy <= busy_d;
            o_done <= done_d;
        end
    end

    // ==========================================================
    // checks
    logic [5:0] low_len_q;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) low_len_q <= mux_write_pkg::CNT_RST;
        else if (i_ce) low_len_q <= o_host_data_strobe_low ? 6'h01 : low_len_q + 6'h01;
    end

    sequence s_data_held;
        o_ad_oe && o_ad_out == data_q;
    endsequence

    a_addr_with_cs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_chip_select_low) |-> o_ad_oe && o_ad_out == addr_q)
        else $error("address not driven with chip select");
    a_cs_strobe_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_host_data_strobe_low) |-> !o_chip_select_low && cs_age_q >= mux_write_pkg::CS2STROBE_MIN)
        else $error("strobe too soon after chip select");
    a_strobe_width: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_host_data_strobe_low) |-> $past(low_len_q) >= mux_write_pkg::STROBE_MIN)
        else $error("strobe pulse too short");
    a_data_setup: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $fell(o_host_data_strobe_low) |-> s_data_held)
        else $error("data not valid at strobe");
    a_data_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_host_data_strobe_low) && i_ce |-> s_data_held ##1 (s_data_held or !i_ce))
        else $error("data not held after strobe");
    a_recovery_gap: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_chip_select_low) |-> o_chip_select_low [*2])
        else $error("recovery gap too short");
    a_wait_freeze: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (st_q == mux_write_pkg::ST_STROBE || st_q == mux_write_pkg::ST_ADDR) && rdy_sync_q && i_ce
        |=> st_q == $past(st_q))
        else $error("phase advanced during wait");
    a_addr_extra: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        st_q == mux_write_pkg::ST_ADDR && extra_q && !rdy_sync_q && i_ce |=> st_q == mux_write_pkg::ST_ADDR)
        else $error("address phase left right after wait");
    a_phase_order: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $changed(st_q) && st_q == mux_write_pkg::ST_STROBE |-> $past(st_q) == mux_write_pkg::ST_SETUP)
        else $error("strobe not preceded by setup");
endmodule // mux_write_seq

`default_nettype wire

// >>> rtl/mux_write_pkg.sv
// constants for the multiplexed host-port write sequencer
package mux_write_pkg;
    // ==========================================================
    // widths
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 6;
    // ==========================================================
    // phase limits, in expansion bus clock periods
    localparam logic [5:0] ADDR_MIN = 6'h0B;      // 11
    localparam logic [5:0] ADDR_MAX = 6'h2D;      // 45
    localparam logic [5:0] CS2STROBE_MIN = 6'h22; // 34
    localparam logic [5:0] STROBE_MIN = 6'h04;    // 4
    localparam logic [5:0] STROBE_MAX = 6'h05;    // 5
    localparam logic [5:0] HOLD_LEN = 6'h04;      // 4, inside 4..36
    localparam logic [5:0] RECOV_MIN = 6'h02;     // 2
    localparam logic [5:0] RECOV_MAX = 6'h11;     // 17
    localparam logic [5:0] SETUP_PARAM_MIN = 6'h02;
    // ==========================================================
    // reset values
    localparam logic [15:0] BUS_RST = 16'h0000;
    localparam logic [5:0] CNT_RST = 6'h00;
    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ADDR   = 6'h02,
        ST_SETUP  = 6'h04,
        ST_STROBE = 6'h08,
        ST_HOLD   = 6'h10,
        ST_RECOV  = 6'h20
    } phase_e;
endpackage

// >>> dv/dsp_host_model.sv
// behavioural dsp host port facing the write sequencer
`timescale 1ns/1ps
`default_nettype none

module dsp_host_model (
    input wire logic i_mclk,                 // bus clock
    input wire logic i_chip_select_low,      // chip select from the sequencer
    input wire logic i_host_data_strobe_low, // strobe from the sequencer
    input wire logic [15:0] i_ad_out,        // multiplexed bus
    input wire logic [1:0] i_stall_mode,     // 0 none, 1 address phase, 2 strobe phase
    input wire logic [5:0] i_wait_len,       // wait length in clocks
    output logic o_host_ready_wait,          // wait request, high = hold
    output logic [15:0] o_got_addr,          // address taken as chip select falls
    output logic [15:0] o_got_data           // data taken as the strobe rises
);
    logic cs_q;
    logic stb_q;
    logic [5:0] n_q;
    logic [5:0] w_q = 6'h00;
    // ==========================================================
    // capture and wait generation
    always_ff @(posedge i_mclk) begin
        cs_q <= i_chip_select_low;
        stb_q <= i_host_data_strobe_low;
        n_q <= i_chip_select_low ? 6'h00 : n_q + 6'h01;
        if (cs_q && !i_chip_select_low) o_got_addr <= i_ad_out;
        if (!stb_q && i_host_data_strobe_low) o_got_data <= i_ad_out;
        // one wait per access, raised at a fixed point so the stretch is predictable
        if (i_stall_mode == 2'h1 && !i_chip_select_low && n_q == 6'h02) w_q <= i_wait_len;
        else if (i_stall_mode == 2'h2 && stb_q && !i_host_data_strobe_low) w_q <= i_wait_len;
        else if (w_q != 6'h00) w_q <= w_q - 6'h01;
    end
    assign o_host_ready_wait = (w_q != 6'h00);
endmodule // dsp_host_model
`default_nettype wire

// >>> dv/tb_host_port_mux_write_cycle.sv
// self-checking bench for the multiplexed host-port write sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_host_port_mux_write_cycle;
    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic i_wr_req = 1'b0;
    logic [15:0] i_wr_addr = 16'h0000;
    logic [15:0] i_wr_data = 16'h0000;
    logic [5:0] p_addr = 6'h0B, p_setup = 6'h02, p_strobe = 6'h04, p_recov = 6'h02;
    logic [1:0] stall_mode = 2'h0;
    logic [5:0] wait_len = 6'h00;
    logic o_chip_select_low, o_host_data_strobe_low, o_ad_oe, o_busy, o_done, ready_wait;
    logic [15:0] o_ad_out, got_addr, got_data;
    int fail_count = 0;
    int compares = 0;
    // address, setup, strobe, recovery params, stall mode, wait, expected pre-strobe, strobe, recovery
    int tab [6][9] = '{'{11, 2, 4, 2, 0, 0, 34, 4, 2}, '{45, 2, 5, 17, 0, 0, 48, 5, 17},
        '{0, 2, 9, 63, 0, 0, 34, 5, 17}, '{20, 20, 4, 5, 0, 0, 41, 4, 5},
        '{30, 10, 5, 3, 1, 5, 47, 5, 3}, '{30, 10, 5, 3, 2, 3, 41, 8, 3}};

    always #2 i_mclk = ~i_mclk;

    mux_write_seq dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_wr_req(i_wr_req),
        .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_address_phase_param(p_addr),
        .i_setup_phase_param(p_setup), .i_strobe_phase_param(p_strobe), .i_recovery_phase_param(p_recov),
        .i_host_ready_wait(ready_wait), .o_chip_select_low(o_chip_select_low),
        .o_host_data_strobe_low(o_host_data_strobe_low), .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe),
        .o_busy(o_busy), .o_done(o_done));
    dsp_host_model far (.i_mclk(i_mclk), .i_chip_select_low(o_chip_select_low),
        .i_host_data_strobe_low(o_host_data_strobe_low), .i_ad_out(o_ad_out), .i_stall_mode(stall_mode),
        .i_wait_len(wait_len), .o_host_ready_wait(ready_wait), .o_got_addr(got_addr), .o_got_data(got_data));

    // ==========================================================
    // compare and close
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_idle();
        check({14'h0000, o_chip_select_low, o_host_data_strobe_low}, 16'h0003);
        check({14'h0000, o_ad_oe, o_busy}, 16'h0000);
    endtask

    // ==========================================================
    // one access; phases are counted at falling edges where registered outputs are settled
    task automatic do_write(input logic [15:0] a, input logic [15:0] d, input int e_pre, input int e_stb,
            input int e_rec);
        int n [4];
        int k;
        n = '{0, 0, 0, 0};
        i_wr_addr = a;
        i_wr_data = d;
        i_wr_req = 1'b1;
        @(negedge i_mclk);
        i_wr_req = 1'b0;
        for (k = 0; k < 300 && o_done !== 1'b1; k++) begin
            if (o_host_data_strobe_low === 1'b0) begin
                n[1]++;
                check(o_ad_out, d);
                check({14'h0000, o_ad_oe, o_busy}, 16'h0003);
            end else if (o_chip_select_low === 1'b0 && n[1] == 0) begin
                n[0]++;
                check(o_ad_out, a);
                check({14'h0000, o_ad_oe, o_busy}, 16'h0003);
            end else if (o_chip_select_low === 1'b0) begin
                n[2]++;
                check(o_ad_out, d);
                check({14'h0000, o_ad_oe, o_busy}, 16'h0003);
            end else begin
                n[3]++;
                check({15'h0000, o_ad_oe}, 16'h0000);
                check({14'h0000, o_host_data_strobe_low, o_busy}, 16'h0003);
            end
            @(negedge i_mclk);
        end
        if (k == 300) begin
            check(16'(k), 16'h0000);
            test_done();
        end
        check(16'(n[0]), 16'(e_pre));
        check(16'(n[1]), 16'(e_stb));
        check(16'(n[2]), 16'h0004);
        check(16'(n[3]), 16'(e_rec));
        check({15'h0000, o_busy}, 16'h0000);
        check(got_addr, a);
        check(got_data, d);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(negedge i_mclk);
        check_idle();
        i_rst_b = 1'b1;
        // reset in mid-access must abandon it cleanly
        i_wr_req = 1'b1;
        @(negedge i_mclk);
        i_wr_req = 1'b0;
        repeat (10) @(negedge i_mclk);
        i_rst_b = 1'b0;
        repeat (4) @(negedge i_mclk);
        check_idle();
        i_rst_b = 1'b1;
        // accesses run back to back: each request after the first is raised in the done cycle of the last
        for (int i = 0; i < 6; i++) begin
            p_addr = 6'(tab[i][0]);
            p_setup = 6'(tab[i][1]);
            p_strobe = 6'(tab[i][2]);
            p_recov = 6'(tab[i][3]);
            stall_mode = 2'(tab[i][4]);
            wait_len = 6'(tab[i][5]);
            do_write(16'hA000 + 16'(i), 16'h5A00 + 16'(i), tab[i][6], tab[i][7], tab[i][8]);
        end
        // the done pulse lasts a single cycle
        @(negedge i_mclk);
        check({15'h0000, o_done}, 16'h0000);
        // with the clock enable low a pending request must not be taken
        i_ce = 1'b0;
        i_wr_req = 1'b1;
        repeat (3) @(negedge i_mclk);
        check({14'h0000, o_chip_select_low, o_busy}, 16'h0002);
        i_ce = 1'b1;
        @(negedge i_mclk);
        i_wr_req = 1'b0;
        check({14'h0000, o_chip_select_low, o_busy}, 16'h0001);
        test_done();
    end
endmodule // tb_host_port_mux_write_cycle
`default_nettype wire
